// [hw/cmpx_map.vh]
// register offsets, field positions and reset values of the comparator control block
// assumes an 8-bit special function register bus with byte addresses
`ifndef CMPX_MAP_VH
`define CMPX_MAP_VH

`define CMPX_ADDR_CTRL      8'h9b
`define CMPX_ADDR_MODE      8'h9d
`define CMPX_ADDR_XIE       8'he6

`define CMPX_CTRL_RESET     8'h00
`define CMPX_MODE_RESET     8'h02
`define CMPX_XIE_RESET      8'h00

`define CMPX_CTRL_EN_BIT    7
`define CMPX_CTRL_OUT_BIT   6
`define CMPX_CTRL_RISE_BIT  5
`define CMPX_CTRL_FALL_BIT  4
`define CMPX_CTRL_HYP_HI    3
`define CMPX_CTRL_HYP_LO    2
`define CMPX_CTRL_HYN_HI    1
`define CMPX_CTRL_HYN_LO    0

`define CMPX_MODE_RIE_BIT   5
`define CMPX_MODE_FIE_BIT   4
`define CMPX_MODE_MD_HI     1
`define CMPX_MODE_MD_LO     0
`define CMPX_MODE_MASK      8'h33

`define CMPX_XIE_CMP_BIT    5
`define CMPX_XIE_RSVD_BIT   1

`endif

// [hw/cmpx_edge_detect.v]
// synchroniser and edge detector for the raw comparator result
// assumes the analog result is asynchronous to clk
module cmpx_edge_detect
(
  input  wire clk,
  input  wire rst,
  input  wire rawIn,
  output wire syncOut,
  output wire riseEv,
  output wire fallEv
);

  reg meta_r;
  reg sync_r;
  reg prev_r;

  // three flops, two of them the synchroniser: meta_r is read only by sync_r, prev_r holds the last sync_r
  always @(posedge clk)
  begin
    if (rst)
    begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end
    else
    begin
      meta_r <= rawIn;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign syncOut = sync_r;
  assign riseEv  = sync_r & ~prev_r; // see (RULE17)
  assign fallEv  = ~sync_r & prev_r; // see (RULE17)

endmodule

// [hw/cmpx_ctrl.v]
// comparator control and status logic with edge flags and interrupt request
// assumes a one-cycle special function register access from the processor core
//
// Notes on behaviour
// (RULE1) comparator runs while control bit 7 is one.
// (RULE2) disabled comparator: pin output low, analog power removed.
// (RULE3) control bit 6 reads the comparator result, read only.
// (RULE4) rising edge sets sticky flag bit 5 until software clears.
// (RULE5) falling edge sets sticky flag bit 4 until software clears.
// (RULE6) positive hysteresis code bits 3:2 drive the comparator.
// (RULE7) negative hysteresis code bits 1:0 drive the comparator.
// (RULE8) mode bit 5 enables the rising-edge interrupt.
// (RULE9) mode bit 4 enables the falling-edge interrupt.
// (RULE10) response mode bits 1:0, reset to 10, drive the comparator.
// (RULE11) mode bits 7:6 and 3:2 read zero, writes ignored.
// (RULE12) extended enable bit 5 gates all comparator interrupts.
// (RULE13) pin output offered synchronised or raw; raw works without clock.
// (RULE14) extended enable holds separate masks for the other sources.
// (RULE15) software writes zero to extended enable bit 1.
// (RULE16) result can be polled, raise interrupts and reach a pin.
// (RULE17) edges from synchronised result; set beats a clear.
// (RULE18) interrupt when group mask and an enabled flag are set.
`include "cmpx_map.vh"

module cmpx_ctrl
(
  input  wire       clk,
  input  wire       rst,
  input  wire [7:0] sfrAddr,
  input  wire       sfrWr,
  input  wire       sfrRd,
  input  wire [7:0] sfrWdata,
  output reg  [7:0] sfrRdata,
  input  wire       cmpRawResult,
  input  wire       pinSyncSel,
  output wire       cmpPinOut,
  output wire       cmpEnable,
  output wire       cmpPowerOn,
  output wire [1:0] cmpPosHysteresis,
  output wire [1:0] cmpNegHysteresis,
  output wire [1:0] cmpResponseMode,
  output wire       cmpIrq,
  output wire       timerThreeIrqMask,
  output wire       secondCmpIrqMask,
  output wire       counterArrayIrqMask,
  output wire       conversionDoneIrqMask,
  output wire       windowCompareIrqMask,
  output wire       twoWireIrqMask
);

  ////////////////////////////////////////////////////////////////////////////
  // register state

  reg       enable_r;
  reg       riseFlag_r;
  reg       fallFlag_r;
  reg [1:0] posHyst_r;
  reg [1:0] negHyst_r;
  reg       riseIe_r;
  reg       fallIe_r;
  reg [1:0] respMode_r;
  reg [7:0] xie_r;

  reg       riseFlag_nxt;
  reg       fallFlag_nxt;

  wire syncResult;
  wire riseEv;
  wire fallEv;

  // one byte-address compare shared by the write decode and the read decode
  function addrHit;
    input [7:0] addr;
    input [7:0] match;
    begin
      addrHit = (addr == match);
    end
  endfunction

  wire wrCtrl = sfrWr && addrHit(sfrAddr, `CMPX_ADDR_CTRL);
  wire wrMode = sfrWr && addrHit(sfrAddr, `CMPX_ADDR_MODE);
  wire wrXie  = sfrWr && addrHit(sfrAddr, `CMPX_ADDR_XIE);

  ////////////////////////////////////////////////////////////////////////////
  // result synchroniser and edge detector

  cmpx_edge_detect uEdge
  (
    .clk     (clk),
    .rst     (rst),
    .rawIn   (cmpRawResult),
    .syncOut (syncResult),
    .riseEv  (riseEv),
    .fallEv  (fallEv)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sticky flags: an edge in the clearing cycle wins

  always @*
  begin
    riseFlag_nxt = riseFlag_r;
    fallFlag_nxt = fallFlag_r;
    if (wrCtrl)
    begin
      riseFlag_nxt = sfrWdata[`CMPX_CTRL_RISE_BIT];
      fallFlag_nxt = sfrWdata[`CMPX_CTRL_FALL_BIT];
    end
    // edges only count while enabled; power-down glitches still in the synchroniser when enable sets can still leave a flag
    if (enable_r && riseEv)
      riseFlag_nxt = 1'b1; // see (RULE4) see (RULE17)
    if (enable_r && fallEv)
      fallFlag_nxt = 1'b1; // see (RULE5) see (RULE17)
  end

  ////////////////////////////////////////////////////////////////////////////
  // register writes

  always @(posedge clk)
  begin
    if (rst)
    begin
      enable_r   <= 1'b0;
      riseFlag_r <= 1'b0;
      fallFlag_r <= 1'b0;
      posHyst_r  <= 2'h0;
      negHyst_r  <= 2'h0;
      riseIe_r   <= 1'b0;
      fallIe_r   <= 1'b0;
      respMode_r <= 2'h2; // see (RULE10)
      xie_r      <= `CMPX_XIE_RESET;
    end
    else
    begin
      riseFlag_r <= riseFlag_nxt;
      fallFlag_r <= fallFlag_nxt;
      if (wrCtrl)
      begin
        enable_r  <= sfrWdata[`CMPX_CTRL_EN_BIT]; // see (RULE1)
        posHyst_r <= sfrWdata[`CMPX_CTRL_HYP_HI:`CMPX_CTRL_HYP_LO]; // see (RULE6)
        negHyst_r <= sfrWdata[`CMPX_CTRL_HYN_HI:`CMPX_CTRL_HYN_LO]; // see (RULE7)
      end
      if (wrMode)
      begin
        riseIe_r   <= sfrWdata[`CMPX_MODE_RIE_BIT]; // see (RULE8)
        fallIe_r   <= sfrWdata[`CMPX_MODE_FIE_BIT]; // see (RULE9)
        respMode_r <= sfrWdata[`CMPX_MODE_MD_HI:`CMPX_MODE_MD_LO]; // see (RULE10) see (RULE11)
      end
      // bit 1 is stored as written; software is expected to keep it zero
      if (wrXie)
        xie_r <= sfrWdata; // see (RULE14) see (RULE15)
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data, registered on the read strobe and held until the next read

  wire       resultBit = enable_r & syncResult;
  wire [7:0] ctrlView  = {enable_r, resultBit, riseFlag_r, fallFlag_r, posHyst_r, negHyst_r}; // see (RULE3) see (RULE16)
  wire [7:0] modeView  = {2'h0, riseIe_r, fallIe_r, 2'h0, respMode_r} & `CMPX_MODE_MASK; // see (RULE11)

  always @(posedge clk)
  begin
    if (rst)
      sfrRdata <= 8'h00;
    else if (sfrRd)
    begin
      if (addrHit(sfrAddr, `CMPX_ADDR_CTRL))
        sfrRdata <= ctrlView;
      else if (addrHit(sfrAddr, `CMPX_ADDR_MODE))
        sfrRdata <= modeView;
      else if (addrHit(sfrAddr, `CMPX_ADDR_XIE))
        sfrRdata <= xie_r;
      else
        sfrRdata <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // analog controls, pin output and interrupt

  assign cmpEnable        = enable_r; // see (RULE1)
  assign cmpPowerOn       = enable_r; // see (RULE2)
  assign cmpPosHysteresis = posHyst_r;
  assign cmpNegHysteresis = negHyst_r;
  assign cmpResponseMode  = respMode_r;

  // raw path has no flop so it still follows the comparator with clk stopped
  assign cmpPinOut = enable_r & (pinSyncSel ? syncResult : cmpRawResult); // see (RULE2) see (RULE13)

  assign cmpIrq = xie_r[`CMPX_XIE_CMP_BIT] &
                  ((riseFlag_r & riseIe_r) | (fallFlag_r & fallIe_r)); // see (RULE12) see (RULE18)

  assign timerThreeIrqMask     = xie_r[7];
  assign secondCmpIrqMask      = xie_r[6];
  assign counterArrayIrqMask   = xie_r[4];
  assign conversionDoneIrqMask = xie_r[3];
  assign windowCompareIrqMask  = xie_r[2];
  assign twoWireIrqMask        = xie_r[0];

endmodule

// [dv/cmpx_ctrl_properties.sv]
// concurrent checks on the ports of the comparator control block
// assumes a bind from the bench top, synchronous active-high reset
module cmpx_ctrl_properties
(
  input logic       clk,
  input logic       rst,
  input logic [7:0] sfrAddr,
  input logic       sfrWr,
  input logic       sfrRd,
  input logic [7:0] sfrWdata,
  input logic [7:0] sfrRdata,
  input logic       cmpPinOut,
  input logic       cmpEnable,
  input logic       cmpPowerOn,
  input logic [1:0] cmpResponseMode,
  input logic       cmpIrq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  a_power_tracks_en: assert property (cmpPowerOn == cmpEnable) else $error("power differs from enable");
  a_pin_low_off: assert property (!cmpEnable |-> !cmpPinOut) else $error("pin high while off");
  a_mode_after_reset: assert property (disable iff (1'b0) rst |=> cmpResponseMode == 2'b10)
    else $error("mode not at reset code");
  a_mode_write: assert property (sfrWr && sfrAddr == 8'h9d |=> cmpResponseMode == 2'($past(sfrWdata)))
    else $error("mode write lost");
  a_enable_write: assert property (sfrWr && sfrAddr == 8'h9b |=> cmpEnable == 1'($past(sfrWdata) >> 7))
    else $error("enable write lost");
  a_mode_unused_zero: assert property (sfrRd && sfrAddr == 8'h9d |=> (sfrRdata & 8'hcc) == 8'h00)
    else $error("unused mode bits read set");
  a_unmapped_read: assert property (sfrRd && !(sfrAddr inside {8'h9b, 8'h9d, 8'he6}) |=> sfrRdata == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_holds: assert property (!sfrRd |=> $stable(sfrRdata)) else $error("read data moved");
  a_group_mask_off: assert property (sfrWr && sfrAddr == 8'he6 && !sfrWdata[5] |=> !cmpIrq)
    else $error("request passes cleared mask");
  a_result_off: assert property (sfrRd && sfrAddr == 8'h9b && !cmpEnable && !sfrWr |=> !sfrRdata[6])
    else $error("result set while off");
  cover property (cmpIrq);
  cover property ($rose(cmpPinOut));
  cover property (sfrRd && sfrAddr == 8'he6);
endmodule

// [dv/cmpx_analog_model.sv]
// stand-in for the analog comparator behind the control block
// assumes target is the bench's input polarity, 1 = positive above negative
module cmpx_analog_model
(
  input  logic clk,
  input  logic powerOn,
  input  logic slow,
  input  logic target,
  output logic rawOut
);
  timeunit 1ns;
  timeprecision 1ns;
  logic late = 1'b0;
  initial rawOut = 1'b0;
  always @(posedge clk)
  begin
    late <= target;
    // unpowered output means nothing, so it toggles rather than hold a value
    // power is unknown until the block's reset lands: treat that as off, keep the output known
    rawOut <= (powerOn !== 1'b1) ? !rawOut : slow ? late : target;
  end
endmodule

// [dv/tb_cmpx_ctrl.sv]
// self-checking bench of the comparator control block
// assumes cmpx_ctrl, the checker and the analog model are compiled first
module tb_cmpx_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk, rst, sfrWr, sfrRd, target, pinSyncSel, raw, pinOut, en, pwr, irq;
  logic [7:0] sfrAddr, sfrWdata, sfrRdata, lf, ctl, mde, xie;
  logic [1:0] hyP, hyN, md;
  wire  [5:0] msk;
  logic [7:0] adr [4] = '{8'h9b, 8'h9d, 8'he6, 8'h9c};
  int         miscompares, checked, cyc;
  ////////////////////////////////////////
  cmpx_ctrl dut_u (.clk(clk), .rst(rst), .sfrAddr(sfrAddr), .sfrWr(sfrWr), .sfrRd(sfrRd), .sfrWdata(sfrWdata),
    .sfrRdata(sfrRdata), .cmpRawResult(raw), .pinSyncSel(pinSyncSel), .cmpPinOut(pinOut), .cmpEnable(en),
    .cmpPowerOn(pwr), .cmpPosHysteresis(hyP), .cmpNegHysteresis(hyN), .cmpResponseMode(md), .cmpIrq(irq),
    .timerThreeIrqMask(msk[5]), .secondCmpIrqMask(msk[4]), .counterArrayIrqMask(msk[3]),
    .conversionDoneIrqMask(msk[2]), .windowCompareIrqMask(msk[1]), .twoWireIrqMask(msk[0]));
  cmpx_analog_model cmp_u (.clk(clk), .powerOn(pwr), .slow(md[1]), .target(target), .rawOut(raw));
  initial
  begin
    clk = 1'b0;
    forever #25 clk = !clk;
  end
  function automatic logic [7:0] nx(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfrAddr <= a;
    sfrWdata <= d;
    sfrWr <= 1'b1;
    @(posedge clk);
    sfrWr <= 1'b0;
    if (a == 8'h9b) ctl = d & 8'hbf;
    if (a == 8'h9d) mde = d & 8'h33;
    if (a == 8'he6) xie = d;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a);
    logic [7:0] ex;
    sfrAddr <= a;
    sfrRd <= 1'b1;
    @(posedge clk);
    sfrRd <= 1'b0;
    @(posedge clk);
    ex = a == 8'h9b ? ctl | {1'b0, ctl[7] & target, 6'h0} : a == 8'h9d ? mde : a == 8'he6 ? xie : 8'h00;
    chk("rdata", sfrRdata, ex);
  endtask
  task automatic outs;
    logic [7:0] ex;
    foreach (adr[i]) rd(adr[i]);
    chk("cfg", {en, pwr, hyP, hyN, md}, {ctl[7], ctl[7], ctl[3:0], mde[1:0]});
    ex = {xie[5] & |(ctl[5:4] & mde[5:4]), ctl[7] & target, xie[7:6], xie[4:2], xie[0]};
    chk("irq", {irq, pinOut, msk}, ex);
  endtask
  task automatic setT(input logic v);
    // edges only count while enabled
    if (ctl[7] && v !== target) ctl = ctl | (v ? 8'h20 : 8'h10);
    target <= v;
    repeat (8) @(posedge clk);
    outs();
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      miscompares++;
      conclude();
    end
  end
  initial
  begin
    {rst, sfrWr, sfrRd, target, pinSyncSel} = 5'b10000;
    {sfrAddr, sfrWdata, lf, ctl, mde, xie} = {16'h0, 8'h42, 8'h0, 8'h02, 8'h0};
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    outs();
    $display("test reset values done");
    repeat (8)
    begin
      lf = nx(lf);
      wr(8'h9d, lf);
      wr(8'he6, lf & 8'hfd);
      wr(8'h9b, lf & 8'h0f);
      wr(8'h9c, lf);
      outs();
    end
    $display("test register access done");
    for (int k = 0; k < 2; k++)
    begin
      pinSyncSel <= k[0];
      wr(8'h9d, 8'h33);
      wr(8'he6, 8'h20);
      wr(8'h9b, 8'h80);
      repeat (8) @(posedge clk);
      wr(8'h9b, 8'h80);
      setT(1'b1);
      setT(1'b0);
      // slow mode: the rise reaches the flag at the very edge that takes the clearing write
      target <= 1'b1;
      repeat (4) @(posedge clk);
      wr(8'h9b, 8'h80);
      ctl = 8'ha0;
      outs();
      wr(8'he6, 8'h00);
      outs();
      wr(8'h9b, 8'h30);
      setT(1'b1);
    end
    $display("test edges and requests done");
    conclude();
  end
endmodule
bind cmpx_ctrl cmpx_ctrl_properties chk_u (.clk(clk), .rst(rst), .sfrAddr(sfrAddr), .sfrWr(sfrWr), .sfrRd(sfrRd),
  .sfrWdata(sfrWdata), .sfrRdata(sfrRdata), .cmpPinOut(cmpPinOut), .cmpEnable(cmpEnable), .cmpPowerOn(cmpPowerOn),
  .cmpResponseMode(cmpResponseMode), .cmpIrq(cmpIrq));
